// ===== rtl/pkoz_consts.svh
// Constants for the pixel keying, overscan, zoom and check block
// Functional notes
// RULE1: Key = product of (match OR ignore bit) over four channels, XOR invert bit.
// RULE2: A channel matches when low bound <= value <= high bound, inclusive.
// RULE3: Key one shows palette graphics; key zero shows direct color.
// RULE4: VGA port enable picks VGA data for palette compare and keying, else overlay.
// RULE5: Software keys overlay only in overlay modes, VGA only at 1:1 multiplex.
// RULE6: Reset clears the four ignore bits and sets the invert bit.
// RULE7: Palette compare is 8-bit; narrow overlay low, page register fills upper bits.
// RULE8: Narrow direct-color channels are left-aligned, low bits zero, before compare.
// RULE9: Window switch OR key selects palette graphics, overlay or VGA by port enable.
// RULE10: General control bit 6 enables border; bit 7 picks internal timing.
// RULE11: Width pin acts as border strobe only when config bit one set.
// RULE12: External mode: border color when strobe high and blank active.
// RULE13: Internal mode: border color when blank active and both syncs inactive.
// RULE14: Pedestal when strobe high and blank low if border on, else blank low.
// RULE15: Internal blank comes from VGA blank when VGA enabled, else system blank.
// RULE16: Strobe path: two-stage sampling then dot-clock delay matching blank path.
// RULE17: Aux bits 7:5 set zoom 1x..32x; each pixel repeats that many dot clocks.
// RULE18: Software scales load clock ratio by zoom and changes zoom in retrace.
// RULE19: Zoom only on pixel port, forced off while VGA port enabled.
// RULE20: Check runs only in active area, latched at second hsync rise in vsync.
// RULE21: Select 0..23 picks one DAC line; result read as low and high bytes.
// RULE22: Check uses polynomial x^16 + x^15 + x^2 + 1, serial on one line.
// RULE23: Accumulator reseeds to zero at the start of each frame active area.
`ifndef PKOZ_CONSTS_SVH
`define PKOZ_CONSTS_SVH
`define PKOZ_ADDR_KEY_CTRL 12'h000
`define PKOZ_ADDR_KEY_PAL 12'h004
`define PKOZ_ADDR_KEY_RED 12'h008
`define PKOZ_ADDR_KEY_GRN 12'h00c
`define PKOZ_ADDR_KEY_BLU 12'h010
`define PKOZ_ADDR_GEN_CTRL 12'h014
`define PKOZ_ADDR_CONFIG 12'h018
`define PKOZ_ADDR_MUX2 12'h01c
`define PKOZ_ADDR_AUX_CTRL 12'h020
`define PKOZ_ADDR_BORDER 12'h024
`define PKOZ_ADDR_PAGE 12'h028
`define PKOZ_ADDR_LINE_SEL 12'h02c
`define PKOZ_ADDR_RES_LOW 12'h030
`define PKOZ_ADDR_RES_HIGH 12'h034
`define PKOZ_KEY_CTRL_RST 8'h10
`define PKOZ_GEN_BORDER_EN 6
`define PKOZ_GEN_INTERNAL 7
`define PKOZ_CFG_WIDTH 0
`define PKOZ_CFG_STROBE 1
`define PKOZ_MUX2_VGA 7
`define PKOZ_AUX_ZOOM_LSB 5
`define PKOZ_AUX_ZOOM_MSB 7
`define PKOZ_KEY_INVERT 4
`define PKOZ_CRC_POLY 16'h8005
`define PKOZ_LINE_MAX 5'h17
`define PKOZ_PIPE_DEPTH 2
`endif

// ===== rtl/pkoz_pkg.sv
// Types for the pixel keying, overscan, zoom and check block
package pkoz_pkg;
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pkoz_rgb_s;
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } pkoz_range_s;
  typedef enum logic [1:0] {
    PKOZ_SRC_DIRECT,
    PKOZ_SRC_PALETTE,
    PKOZ_SRC_BORDER
  } pkoz_src_e;
endpackage

// ===== rtl/pkoz_pixel_path.sv
// Pixel keying, overscan border, horizontal zoom and line check with APB registers
`timescale 1ns/1ps
`include "pkoz_consts.svh"
module pkoz_pixel_path
  import pkoz_pkg::*;
#(
  parameter int DC_BITS = 8,
  parameter int OL_BITS = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3*DC_BITS-1:0] direct_pixel,
  input wire logic [OL_BITS-1:0] overlay_pixel,
  input wire logic [7:0] vga_pixel,
  input wire pkoz_rgb_s palette_rgb,
  input wire logic window_switch,
  input wire logic border_strobe_in,
  input wire logic system_blank_n,
  input wire logic vga_blank_n,
  input wire logic hsync_n,
  input wire logic vsync_n,
  output pkoz_rgb_s dac_rgb,
  output logic [7:0] palette_index,
  output pkoz_src_e pixel_source,
  output logic pedestal_on,
  output logic pixel_load
);

  // Control registers
  logic [7:0] key_ctrl;
  pkoz_range_s key_pal, key_red, key_grn, key_blu;
  logic [7:0] general_control;
  logic [7:0] config_reg;
  logic [7:0] mux_control_two;
  logic [7:0] auxiliary_control;
  pkoz_rgb_s border_rgb;
  logic [7:0] page_reg;
  logic [4:0] check_line_select;
  logic [15:0] check_result;

  // Two-flop synchronisers for pins
  logic [5:0] pin_s1, pin_s2;
  always_ff @(posedge sys_clk) begin
    pin_s1 <= {border_strobe_in, system_blank_n, vga_blank_n, hsync_n, vsync_n, window_switch};
    pin_s2 <= pin_s1;
  end
  wire strobe_s = pin_s2[5];
  wire sys_bl_n_s = pin_s2[4];
  wire vga_bl_n_s = pin_s2[3];
  wire hs_n_s = pin_s2[2];
  wire vs_n_s = pin_s2[1];
  wire win_s = pin_s2[0];

  // Mode decode
  wire vga_en = mux_control_two[`PKOZ_MUX2_VGA];
  wire border_en = general_control[`PKOZ_GEN_BORDER_EN];
  wire border_internal = general_control[`PKOZ_GEN_INTERNAL];
  wire strobe_cfg = config_reg[`PKOZ_CFG_STROBE];
  wire blank_n_int = vga_en ? vga_bl_n_s : sys_bl_n_s; // RULE15
  wire strobe_sel = strobe_cfg & strobe_s; // RULE11

  // Strobe delayed the same depth as the blank path
  logic [`PKOZ_PIPE_DEPTH-1:0] strobe_dly;
  logic [`PKOZ_PIPE_DEPTH-1:0] blank_dly;
  always_ff @(posedge sys_clk) begin
    strobe_dly <= {strobe_dly[`PKOZ_PIPE_DEPTH-2:0], strobe_sel}; // RULE16
    blank_dly <= {blank_dly[`PKOZ_PIPE_DEPTH-2:0], blank_n_int};
  end
  wire strobe_d = strobe_dly[`PKOZ_PIPE_DEPTH-1];
  wire blank_n_d = blank_dly[`PKOZ_PIPE_DEPTH-1];

  // Zoom: hold each pixel for 2^factor dot clocks, one dot clock for factors 6 and 7
  logic [4:0] zoom_cnt;
  wire [2:0] zoom_code = vga_en ? 3'h0 : auxiliary_control[7:5]; // RULE19
  wire [5:0] zoom_len = (zoom_code > 3'h5) ? 6'h01 : (6'h01 << zoom_code); // RULE17
  wire zoom_take = ({1'b0, zoom_cnt} == zoom_len - 6'h01);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      zoom_cnt <= 5'h00;
    end else begin
      zoom_cnt <= zoom_take ? 5'h00 : zoom_cnt + 5'h01;
    end
  end
  logic [3*DC_BITS-1:0] direct_held;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      direct_held <= '0;
    end else if (zoom_take || vga_en) begin
      direct_held <= direct_pixel; // RULE17
    end
  end

  // Left-align direct color channels
  function automatic logic [7:0] align_chan(input logic [DC_BITS-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[7 -: DC_BITS] = v;
    return r;
  endfunction
  wire [7:0] red8 = align_chan(direct_held[3*DC_BITS-1 -: DC_BITS]); // RULE8
  wire [7:0] grn8 = align_chan(direct_held[2*DC_BITS-1 -: DC_BITS]); // RULE8
  wire [7:0] blu8 = align_chan(direct_held[DC_BITS-1:0]); // RULE8

  // Overlay paged into 8 bits
  logic [7:0] ol8;
  always_comb begin
    ol8 = page_reg;
    ol8[OL_BITS-1:0] = overlay_pixel; // RULE7
  end
  wire [7:0] pal_val = vga_en ? vga_pixel : ol8; // RULE4

  function automatic logic in_range(input logic [7:0] v, input pkoz_range_s r);
    return (v >= r.low) && (v <= r.high);
  endfunction
  wire palette_chan_match = in_range(pal_val, key_pal); // RULE2
  wire red_match = in_range(red8, key_red); // RULE2
  wire grn_match = in_range(grn8, key_grn); // RULE2
  wire blu_match = in_range(blu8, key_blu); // RULE2
  wire key_ignore_palette_chan = key_ctrl[0];
  wire key_ignore_red = key_ctrl[1];
  wire key_ignore_green = key_ctrl[2];
  wire key_ignore_blue = key_ctrl[3];
  wire key_invert = key_ctrl[`PKOZ_KEY_INVERT];
  wire key_decision = ((palette_chan_match | key_ignore_palette_chan)
                       & (red_match | key_ignore_red) & (grn_match | key_ignore_green)
                       & (blu_match | key_ignore_blue)) ^ key_invert; // RULE1
  wire use_palette = key_decision | win_s; // RULE3 RULE9

  // Border area
  wire border_ext = ~border_internal & strobe_d & ~blank_n_d; // RULE12
  wire border_int = border_internal & ~blank_n_d & hs_n_s & vs_n_s; // RULE13
  wire border_on = border_en & (border_ext | border_int); // RULE10
  wire next_pedestal = border_en ? (strobe_d & ~blank_n_d) : ~blank_n_d; // RULE14

  pkoz_src_e next_src;
  pkoz_rgb_s next_rgb;
  always_comb begin
    next_src = PKOZ_SRC_DIRECT;
    next_rgb = '{red: red8, green: grn8, blue: blu8};
    if (border_on) begin
      next_src = PKOZ_SRC_BORDER;
      next_rgb = border_rgb;
    end else if (use_palette) begin
      next_src = PKOZ_SRC_PALETTE; // RULE9
      next_rgb = palette_rgb;
    end
  end

  // Registered pixel outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dac_rgb <= '0;
      pixel_source <= PKOZ_SRC_DIRECT;
      pedestal_on <= 1'b0;
      palette_index <= 8'h00;
      pixel_load <= 1'b0;
    end else begin
      dac_rgb <= next_rgb;
      pixel_source <= next_src;
      pedestal_on <= next_pedestal;
      palette_index <= pal_val;
      pixel_load <= zoom_take;
    end
  end

  // Line check: serial polynomial on one DAC line
  wire [23:0] dac_lines = {next_rgb.blue, next_rgb.green, next_rgb.red}; // Aligned with blank_n_d
  wire check_bit = (check_line_select <= `PKOZ_LINE_MAX) ? dac_lines[check_line_select] : 1'b0;
  logic [15:0] check_acc;
  logic in_active, vs_prev, hs_prev;
  logic [1:0] hs_rise_cnt;
  wire active_now = blank_n_d;
  wire vs_start = ~vs_n_s & vs_prev;
  wire hs_rise = ~hs_n_s & hs_prev;
  wire fb = check_acc[15] ^ check_bit;
  wire [15:0] next_check = {check_acc[14:0], 1'b0} ^ (fb ? `PKOZ_CRC_POLY : 16'h0000); // RULE22
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      check_acc <= 16'h0000;
      check_result <= 16'h0000;
      hs_rise_cnt <= 2'h0;
      vs_prev <= 1'b0;
      hs_prev <= 1'b0;
      in_active <= 1'b0;
    end else begin
      vs_prev <= vs_n_s;
      hs_prev <= hs_n_s;
      in_active <= in_active | active_now;
      if (vs_start) begin
        hs_rise_cnt <= 2'h0;
      end else if (~vs_n_s && hs_rise && hs_rise_cnt != 2'h2) begin
        hs_rise_cnt <= hs_rise_cnt + 2'h1;
        if (hs_rise_cnt == 2'h1) begin
          check_result <= check_acc; // RULE20
          in_active <= 1'b0;
        end
      end
      if (active_now && !in_active) begin
        check_acc <= check_bit ? `PKOZ_CRC_POLY : 16'h0000; // RULE23
      end else if (active_now) begin
        check_acc <= next_check; // RULE20
      end
    end
  end

  // APB slave: one wait-free access phase
  wire wr = psel & penable & pwrite;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `PKOZ_ADDR_KEY_CTRL: rd_mux = {24'h0, key_ctrl};
      `PKOZ_ADDR_KEY_PAL: rd_mux = {16'h0, key_pal};
      `PKOZ_ADDR_KEY_RED: rd_mux = {16'h0, key_red};
      `PKOZ_ADDR_KEY_GRN: rd_mux = {16'h0, key_grn};
      `PKOZ_ADDR_KEY_BLU: rd_mux = {16'h0, key_blu};
      `PKOZ_ADDR_GEN_CTRL: rd_mux = {24'h0, general_control};
      `PKOZ_ADDR_CONFIG: rd_mux = {24'h0, config_reg};
      `PKOZ_ADDR_MUX2: rd_mux = {24'h0, mux_control_two};
      `PKOZ_ADDR_AUX_CTRL: rd_mux = {24'h0, auxiliary_control};
      `PKOZ_ADDR_BORDER: rd_mux = {8'h0, border_rgb};
      `PKOZ_ADDR_PAGE: rd_mux = {24'h0, page_reg};
      `PKOZ_ADDR_LINE_SEL: rd_mux = {27'h0, check_line_select};
      `PKOZ_ADDR_RES_LOW: rd_mux = {24'h0, check_result[7:0]}; // RULE21
      `PKOZ_ADDR_RES_HIGH: rd_mux = {24'h0, check_result[15:8]}; // RULE21
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `PKOZ_ADDR_RES_HIGH);

  // Write strobes, one for each writable register
  wire wr_key_ctrl = wr && (paddr == `PKOZ_ADDR_KEY_CTRL);
  wire wr_key_pal = wr && (paddr == `PKOZ_ADDR_KEY_PAL);
  wire wr_key_red = wr && (paddr == `PKOZ_ADDR_KEY_RED);
  wire wr_key_grn = wr && (paddr == `PKOZ_ADDR_KEY_GRN);
  wire wr_key_blu = wr && (paddr == `PKOZ_ADDR_KEY_BLU);
  wire wr_gen_ctrl = wr && (paddr == `PKOZ_ADDR_GEN_CTRL);
  wire wr_config = wr && (paddr == `PKOZ_ADDR_CONFIG);
  wire wr_mux2 = wr && (paddr == `PKOZ_ADDR_MUX2);
  wire wr_aux_ctrl = wr && (paddr == `PKOZ_ADDR_AUX_CTRL);
  wire wr_border = wr && (paddr == `PKOZ_ADDR_BORDER);
  wire wr_page = wr && (paddr == `PKOZ_ADDR_PAGE);
  wire wr_line_sel = wr && (paddr == `PKOZ_ADDR_LINE_SEL);
  // Key control: ignore bits clear and invert set, so palette shows after reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_ctrl <= `PKOZ_KEY_CTRL_RST; // RULE6
    end else if (wr_key_ctrl) begin
      key_ctrl <= {3'h0, pwdata[4:0]};
    end
  end
  // Palette channel key range
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_pal <= '0;
    end else if (wr_key_pal) begin
      key_pal <= pwdata[15:0];
    end
  end
  // Red key range
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_red <= '0;
    end else if (wr_key_red) begin
      key_red <= pwdata[15:0];
    end
  end
  // Green key range
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_grn <= '0;
    end else if (wr_key_grn) begin
      key_grn <= pwdata[15:0];
    end
  end
  // Blue key range
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      key_blu <= '0;
    end else if (wr_key_blu) begin
      key_blu <= pwdata[15:0];
    end
  end
  // General control: border enable and border timing source
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      general_control <= 8'h00;
    end else if (wr_gen_ctrl) begin
      general_control <= pwdata[7:0];
    end
  end
  // Configuration: strobe pin function
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      config_reg <= 8'h00;
    end else if (wr_config) begin
      config_reg <= pwdata[7:0];
    end
  end
  // Mux control two: VGA port enable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mux_control_two <= 8'h00;
    end else if (wr_mux2) begin
      mux_control_two <= pwdata[7:0];
    end
  end
  // Auxiliary control: zoom factor
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      auxiliary_control <= 8'h00;
    end else if (wr_aux_ctrl) begin
      auxiliary_control <= pwdata[7:0];
    end
  end
  // Border colour
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      border_rgb <= '0;
    end else if (wr_border) begin
      border_rgb <= pwdata[23:0];
    end
  end
  // Palette page for narrow overlay data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      page_reg <= 8'h00;
    end else if (wr_page) begin
      page_reg <= pwdata[7:0];
    end
  end
  // Checked DAC line select
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      check_line_select <= 5'h00;
    end else if (wr_line_sel) begin
      check_line_select <= pwdata[4:0]; // RULE21
    end
  end

  // Read data and response registered in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // pkoz_pixel_path

// ===== testbench/pkoz_pixel_src.sv
// Pixel source model: frame-buffer and VGA controller pins plus palette lookup
`timescale 1ns/1ps
module pkoz_pixel_src
  import pkoz_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [53:0] want,
  input wire logic [7:0] palette_index,
  output logic [53:0] pins = 54'h0f,
  output pkoz_rgb_s palette_rgb
);
  // Presents each commanded pixel and timing set on the next dot clock
  always @(posedge sys_clk) begin
    pins <= want;
  end
  // Palette lookup answers at once with a colour made from the index
  assign palette_rgb = {palette_index, ~palette_index, palette_index ^ 8'h5a};
endmodule // pkoz_pixel_src

// ===== testbench/pkoz_pixel_path_sva.sv
// Port checker for the pixel keying, overscan and zoom block
`timescale 1ns/1ps
`include "pkoz_consts.svh"
module pkoz_pixel_path_sva
  import pkoz_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic window_switch,
  input wire pkoz_src_e pixel_source,
  input wire logic pixel_load
);
  logic [2:0] zoom;
  logic vga;
  logic bord;
  logic [5:0] age;
  wire wr_ok = psel && penable && pready && pwrite && !pslverr;
  wire calm = age == 6'h3f;
  wire w8 = age > 6'h07;
  // Shadows of the fields that shape pixel outputs; age counts cycles since a write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      zoom <= 3'h0;
      vga <= 1'h0;
      bord <= 1'h0;
      age <= 6'h0;
    end else begin
      age <= wr_ok ? 6'h0 : age + 6'(!calm);
      if (wr_ok && paddr == `PKOZ_ADDR_AUX_CTRL) zoom <= pwdata[7:5];
      if (wr_ok && paddr == `PKOZ_ADDR_MUX2) vga <= pwdata[7];
      if (wr_ok && paddr == `PKOZ_ADDR_GEN_CTRL) bord <= pwdata[6];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  load_every_1x_a: assert property (calm && zoom == 3'h0 |-> pixel_load)
    else $error("load missing at 1x");
  load_vga_forced_a: assert property (calm && vga |-> pixel_load)
    else $error("zoom not forced off with VGA");
  load_gap_2x_a: assert property (calm && !vga && zoom == 3'h1 && pixel_load
    |=> !pixel_load ##1 (pixel_load || !calm))
    else $error("2x load spacing wrong");
  no_border_off_a: assert property (w8 && !bord |-> pixel_source != PKOZ_SRC_BORDER)
    else $error("border shown while disabled");
  window_palette_a: assert property ((w8 && !bord && zoom == 3'h0 && window_switch)[*5]
    |-> pixel_source == PKOZ_SRC_PALETTE)
    else $error("window did not select palette");
endmodule // pkoz_pixel_path_sva
bind pkoz_pixel_path pkoz_pixel_path_sva u_sva (.sys_clk, .srst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .window_switch, .pixel_source, .pixel_load);

// ===== testbench/pkoz_pixel_path_tb_top.sv
// Self-checking bench for the pixel keying, overscan and zoom block
`timescale 1ns/1ps
`include "pkoz_consts.svh"
module pkoz_pixel_path_tb_top;
  import pkoz_pkg::*;
  logic sys_clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h00015308;
  logic pready, pslverr, pedestal_on, pixel_load, cnt_en = 1'h0;
  logic [53:0] want = 54'h0f, pins;
  logic [7:0] palette_index, loads = 8'h0;
  logic [7:0] v[4];
  logic [1:0] chk = 2'h0;
  logic [15:0] crc = 16'h0;
  logic [31:0] expq[$];
  pkoz_rgb_s palette_rgb, dac_rgb;
  pkoz_src_e pixel_source;
  int miscompares = 0;
  int cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  pkoz_pixel_src u_src (.sys_clk(sys_clk), .want(want), .palette_index(palette_index),
    .pins(pins), .palette_rgb(palette_rgb));
  pkoz_pixel_path u_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .direct_pixel(pins[53:30]), .overlay_pixel(pins[29:22]),
    .vga_pixel(pins[21:14]), .palette_rgb(palette_rgb), .window_switch(pins[5]),
    .border_strobe_in(pins[4]), .system_blank_n(pins[3]), .vga_blank_n(pins[2]),
    .hsync_n(pins[1]), .vsync_n(pins[0]), .dac_rgb(dac_rgb), .palette_index(palette_index),
    .pixel_source(pixel_source), .pedestal_on(pedestal_on), .pixel_load(pixel_load));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] got);
    logic [31:0] e;
    e = expq.pop_front();
    cmp_count++;
    if (got !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, got);
    end
  endtask
  // Oldest note is taken off the queue whenever a result shows
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) cmp("prdata", prdata);
    if (chk == 2'h1) cmp("pixel_source", 32'(pixel_source));
    if (chk == 2'h2) cmp("pixel_load count", 32'(loads));
    if (chk == 2'h3) begin
      cmp("index and rgb", {palette_index, dac_rgb});
      cmp("pedestal_on", 32'(pedestal_on));
    end
    loads <= cnt_en ? loads + 8'(pixel_load) : 8'h0;
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic px(input logic [7:0] vg, input logic [5:0] c);
    want <= {v[1], v[2], v[3], v[0], vg, 8'h0, c};
  endtask
  // Waits out the longest pin latency, then notes and samples the source
  task automatic src(input pkoz_src_e e);
    repeat (6) @(posedge sys_clk);
    expq.push_back(32'(e));
    chk <= 2'h1;
    @(posedge sys_clk);
    chk <= 2'h0;
  endtask
  // Same wait, then notes palette index with colour, and pedestal
  task automatic rgb_chk(input logic [31:0] e, input logic ped);
    repeat (6) @(posedge sys_clk);
    expq.push_back(e);
    expq.push_back(32'(ped));
    chk <= 2'h3;
    @(posedge sys_clk);
    chk <= 2'h0;
  endtask
  // One frame: blank, n active cycles, blank, retrace with two sync pulses
  task automatic frame(input int n);
    want[5:0] <= 6'h03;
    repeat (8) @(posedge sys_clk);
    want[5:0] <= 6'h0f;
    repeat (n) @(posedge sys_clk);
    want[5:0] <= 6'h03;
    repeat (8) @(posedge sys_clk);
    repeat (2) begin
      want[5:0] <= 6'h02;
      repeat (4) @(posedge sys_clk);
      want[5:0] <= 6'h00;
      repeat (4) @(posedge sys_clk);
    end
    want[5:0] <= 6'h03;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic zoom_chk(input logic [2:0] z, input logic [31:0] e);
    want[5:0] <= 6'h0e;
    wr(`PKOZ_ADDR_AUX_CTRL, {24'h0, z, 5'h0});
    want[5:0] <= 6'h0f;
    repeat (64) @(posedge sys_clk);
    cnt_en <= 1'h1;
    repeat (64) @(posedge sys_clk);
    cnt_en <= 1'h0;
    expq.push_back(e);
    chk <= 2'h2;
    @(posedge sys_clk);
    chk <= 2'h0;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    rd(`PKOZ_ADDR_KEY_CTRL, 32'h10);
    rd(12'hffc, 32'h0);
    v = '{8'h05, 8'h10, 8'h20, 8'h30};
    px(8'h05, 6'h0f);
    src(PKOZ_SRC_PALETTE);
    for (int c = 1; c < 5; c++) wr(12'(c * 4), 32'h409f);
    // Each channel in turn just outside its range, the rest random inside; last pass all inside
    for (int k = 0; k < 5; k++) begin
      for (int c = 0; c < 4; c++) begin
        rnd = lfsr(rnd);
        v[c] = (c == k) ? 8'h3f + 8'(k % 2) * 8'h61 : 8'h40 + rnd[7:0] % 8'h60;
      end
      px(8'h00, 6'h0f);
      wr(`PKOZ_ADDR_KEY_CTRL, 32'h0);
      src(k == 4 ? PKOZ_SRC_PALETTE : PKOZ_SRC_DIRECT);
      wr(`PKOZ_ADDR_KEY_CTRL, 32'h1 << k);
      src(k == 4 ? PKOZ_SRC_DIRECT : PKOZ_SRC_PALETTE);
    end
    wr(`PKOZ_ADDR_KEY_CTRL, 32'h0);
    wr(`PKOZ_ADDR_MUX2, 32'h80);
    src(PKOZ_SRC_DIRECT);
    px(8'h9f, 6'h0f);
    src(PKOZ_SRC_PALETTE);
    px(8'h00, 6'h2f);
    src(PKOZ_SRC_PALETTE);
    wr(`PKOZ_ADDR_GEN_CTRL, 32'h40);
    wr(`PKOZ_ADDR_CONFIG, 32'h02);
    wr(`PKOZ_ADDR_BORDER, 32'h0012_3456);
    px(8'h00, 6'h1b);
    src(PKOZ_SRC_BORDER);
    rgb_chk(32'h0012_3456, 1'h1);
    px(8'h00, 6'h17);
    src(PKOZ_SRC_DIRECT);
    wr(`PKOZ_ADDR_GEN_CTRL, 32'hc0);
    px(8'h00, 6'h0b);
    src(PKOZ_SRC_BORDER);
    rgb_chk(32'h0012_3456, 1'h0);
    px(8'h00, 6'h09);
    src(PKOZ_SRC_DIRECT);
    wr(`PKOZ_ADDR_GEN_CTRL, 32'h0);
    wr(`PKOZ_ADDR_LINE_SEL, 32'h17);
    rd(`PKOZ_ADDR_LINE_SEL, 32'h17);
    wr(`PKOZ_ADDR_MUX2, 32'h0);
    for (int z = 0; z < 6; z++) zoom_chk(3'(z), 32'h40 >> z);
    wr(`PKOZ_ADDR_MUX2, 32'h80);
    zoom_chk(3'h5, 32'h40);
    // Fixed picture with blue line 7 high through two active areas, then read the check of the second
    wr(`PKOZ_ADDR_KEY_CTRL, 32'h1f);
    v[3] = 8'h80;
    px(8'h3c, 6'h03);
    rgb_chk({8'h3c, v[1], v[2], v[3]}, 1'h1);
    frame(40);
    frame(40);
    for (int i = 0; i < 40; i++) crc = {crc[14:0], 1'b0} ^ (crc[15] ? 16'h0000 : `PKOZ_CRC_POLY);
    rd(`PKOZ_ADDR_RES_LOW, 32'(crc[7:0]));
    rd(`PKOZ_ADDR_RES_HIGH, 32'(crc[15:8]));
    report_and_stop();
  end
endmodule // pkoz_pixel_path_tb_top
